// file: inc/nvc_regs.svh
// timing and field constants for the nonvolatile sram host controller
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

// system clock period and rounding of least times up to whole cycles
`define NVC_CLK_NS 10
`define NVC_CYC_UP(ns) (((ns) + `NVC_CLK_NS - 1) / `NVC_CLK_NS)

// pin timing, in ns
`define NVC_T_PU_NS 1000000
`define NVC_T_ZZL_NS 1000
`define NVC_T_ZZEX_NS 450000
`define NVC_T_CA_NS 70
`define NVC_T_PC_NS 35
`define NVC_T_PAGE_NS 15

// derived cycle counts for the short waits
`define NVC_CA_CYC `NVC_CYC_UP(`NVC_T_CA_NS)
`define NVC_PC_CYC `NVC_CYC_UP(`NVC_T_PC_NS)
`define NVC_PAGE_CYC `NVC_CYC_UP(`NVC_T_PAGE_NS)
`define NVC_ZZL_CYC `NVC_CYC_UP(`NVC_T_ZZL_NS)

// widths and address split
`define NVC_CNT_W 20
`define NVC_ADDR_W 17
`define NVC_DATA_W 16
`define NVC_UPPER_MSB 16
`define NVC_UPPER_LSB 2
`define NVC_COL_MSB 1
`define NVC_COL_LSB 0
`define NVC_BE_LOW 0
`define NVC_BE_HIGH 1
`define NVC_CNT_ZERO 20'h00000

`endif

// file: inc/nvc_pkg.sv
// types shared by the nonvolatile sram host controller
`include "nvc_regs.svh"

package nvc_pkg;

  typedef logic [`NVC_CNT_W-1:0] nvc_cnt_t;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_IDLE = 4'h1,
    ST_RD_ACC = 4'h2,
    ST_PAGE = 4'h3,
    ST_PG_ACC = 4'h4,
    ST_WR = 4'h5,
    ST_PRECHG = 4'h6,
    ST_SLEEP = 4'h7,
    ST_WAKE = 4'h8
  } nvc_state_e;

endpackage

// file: hdl/nvc_timer.sv
// loadable down counter that marks the end of a pin wait
`timescale 1ns/1ps
`include "nvc_regs.svh"

module nvc_timer #(
  parameter nvc_pkg::nvc_cnt_t RESET_COUNT = `NVC_CNT_ZERO
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic load,
  input wire nvc_pkg::nvc_cnt_t loadValue,
  output logic done
);

  nvc_pkg::nvc_cnt_t count;

  // saturates at zero so done stays high until the next load
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      count <= RESET_COUNT;
    else if (load)
      count <= loadValue;
    else if (count != `NVC_CNT_ZERO)
      count <= count - nvc_pkg::nvc_cnt_t'(1);
  end

  assign done = (count == `NVC_CNT_ZERO);

endmodule

// file: hdl/nvc_host.sv
// host controller driving a 128k x 16 nonvolatile sram-compatible memory
// Functional notes
// - wait 450 us after wake before access
// - sleep may follow last write with no gap
// - no access within 1 ms of power-up
// - page column bits stable 15 ns per access
// - byte selects tied low only without byte writes
`timescale 1ns/1ps
`include "nvc_regs.svh"

module nvc_host #(
  parameter int PU_CYCLES = `NVC_CYC_UP(`NVC_T_PU_NS),
  parameter int WAKE_CYCLES = `NVC_CYC_UP(`NVC_T_ZZEX_NS)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [`NVC_ADDR_W-1:0] reqAddr,
  input wire logic [`NVC_DATA_W-1:0] reqWdata,
  input wire logic [1:0] reqByteEn,
  output logic rspValid,
  output logic [`NVC_DATA_W-1:0] rspRdata,
  input wire logic sleepReq,
  output logic asleep,
  output logic ceN,
  output logic weN,
  output logic oeN,
  output logic upperByteSelectN,
  output logic lowerByteSelectN,
  output logic sleepRequestN,
  output logic [`NVC_UPPER_MSB-`NVC_UPPER_LSB:0] upperAddressBits,
  output logic [`NVC_COL_MSB:0] pageColumnBits,
  input wire logic [`NVC_DATA_W-1:0] dataBusIn,
  output logic [`NVC_DATA_W-1:0] dataBusOut,
  output logic dataBusOe
);

  nvc_pkg::nvc_state_e state;
  logic pendValid;
  logic pendWrite;
  logic [`NVC_ADDR_W-1:0] pendAddr;
  logic [`NVC_DATA_W-1:0] pendData;
  logic [1:0] pendBe;
  logic take;
  logic pageHit;
  logic startOp;
  logic goSleep;
  logic goPrechg;
  logic wakeUp;
  logic tmrLoad;
  logic tmrDone;
  nvc_pkg::nvc_cnt_t tmrValue;

  // upper address compare used by the page decision
  function automatic logic samePage(input logic [`NVC_ADDR_W-1:0] a, input logic [`NVC_ADDR_W-1:0] b);
    samePage = (a[`NVC_UPPER_MSB:`NVC_UPPER_LSB] == b[`NVC_UPPER_MSB:`NVC_UPPER_LSB]);
  endfunction

  // decisions shared by the fsm and the timer loader
  assign take = reqValid && reqReady;
  assign pageHit = (state == nvc_pkg::ST_PAGE) && take && !reqWrite && samePage(reqAddr, pendAddr);
  assign startOp = (state == nvc_pkg::ST_IDLE) && pendValid;
  assign goSleep = (state == nvc_pkg::ST_IDLE) && !pendValid && !take && sleepReq;
  assign goPrechg = ((state == nvc_pkg::ST_WR) && tmrDone) ||
                    ((state == nvc_pkg::ST_PAGE) && ((take && !pageHit) || (!take && sleepReq)));
  assign wakeUp = (state == nvc_pkg::ST_SLEEP) && tmrDone && !sleepReq;

  // wait lengths; each load gives the level count plus one edge
  always_comb
  begin
    tmrLoad = 1'b1;
    tmrValue = `NVC_CNT_ZERO;
    if (startOp)
      tmrValue = nvc_pkg::nvc_cnt_t'(`NVC_CA_CYC - 1);
    else if (pageHit)
      tmrValue = nvc_pkg::nvc_cnt_t'(`NVC_PAGE_CYC - 1);
    else if (goPrechg)
      tmrValue = nvc_pkg::nvc_cnt_t'(`NVC_PC_CYC - 1);
    else if (goSleep)
      tmrValue = nvc_pkg::nvc_cnt_t'(`NVC_ZZL_CYC - 1);
    else if (wakeUp)
      tmrValue = nvc_pkg::nvc_cnt_t'(WAKE_CYCLES - 1);
    else
      tmrLoad = 1'b0;
  end

  // reset stands for the supply reaching its operating level
  nvc_timer #(
    .RESET_COUNT(nvc_pkg::nvc_cnt_t'(PU_CYCLES - 1))
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .done(tmrDone)
  );

  // request capture; a page hit updates the address but needs no start
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pendValid <= 1'b0;
      pendWrite <= 1'b0;
      pendAddr <= {`NVC_ADDR_W{1'b0}};
      pendData <= {`NVC_DATA_W{1'b0}};
      pendBe <= 2'h0;
    end
    else
    begin
      if (take)
      begin
        pendWrite <= reqWrite;
        pendAddr <= reqAddr;
        pendData <= reqWdata;
        pendBe <= reqByteEn;
      end
      if (take && !pageHit)
        pendValid <= 1'b1;
      else if (startOp)
        pendValid <= 1'b0;
    end
  end

  // main sequencer and memory pins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= nvc_pkg::ST_POWERUP;
      reqReady <= 1'b0;
      ceN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
      upperByteSelectN <= 1'b1;
      lowerByteSelectN <= 1'b1;
      sleepRequestN <= 1'b1;
      upperAddressBits <= 15'h0000;
      pageColumnBits <= 2'h0;
      dataBusOut <= 16'h0000;
      dataBusOe <= 1'b0;
      asleep <= 1'b0;
    end
    else
    begin
      unique case (state)
        nvc_pkg::ST_POWERUP:
        begin
          if (tmrDone)
          begin
            state <= nvc_pkg::ST_IDLE;
            reqReady <= 1'b1;
          end
        end
        nvc_pkg::ST_IDLE:
        begin
          if (startOp)
          begin
            // both selects driven from the request so byte writes stay safe
            ceN <= 1'b0;
            weN <= !pendWrite;
            oeN <= pendWrite;
            upperByteSelectN <= !pendBe[`NVC_BE_HIGH];
            lowerByteSelectN <= !pendBe[`NVC_BE_LOW];
            upperAddressBits <= pendAddr[`NVC_UPPER_MSB:`NVC_UPPER_LSB];
            pageColumnBits <= pendAddr[`NVC_COL_MSB:`NVC_COL_LSB];
            dataBusOut <= pendData;
            dataBusOe <= pendWrite;
            state <= pendWrite ? nvc_pkg::ST_WR : nvc_pkg::ST_RD_ACC;
          end
          else if (take)
            reqReady <= 1'b0;
          else if (goSleep)
          begin
            // enable pins already idle high, so the memory sees standby first
            sleepRequestN <= 1'b0;
            asleep <= 1'b1;
            reqReady <= 1'b0;
            state <= nvc_pkg::ST_SLEEP;
          end
          else
            reqReady <= 1'b1;
        end
        nvc_pkg::ST_RD_ACC, nvc_pkg::ST_PG_ACC:
        begin
          if (tmrDone)
          begin
            // chip enable stays low so a following read can use page mode
            reqReady <= 1'b1;
            state <= nvc_pkg::ST_PAGE;
          end
        end
        nvc_pkg::ST_PAGE:
        begin
          if (pageHit)
          begin
            // only the column bits and byte selects move; upper bits keep the open row
            pageColumnBits <= reqAddr[`NVC_COL_MSB:`NVC_COL_LSB];
            upperByteSelectN <= !reqByteEn[`NVC_BE_HIGH];
            lowerByteSelectN <= !reqByteEn[`NVC_BE_LOW];
            reqReady <= 1'b0;
            state <= nvc_pkg::ST_PG_ACC;
          end
          else if (goPrechg)
          begin
            ceN <= 1'b1;
            oeN <= 1'b1;
            reqReady <= 1'b0;
            state <= nvc_pkg::ST_PRECHG;
          end
        end
        nvc_pkg::ST_WR:
        begin
          if (tmrDone)
          begin
            // both enables rise together; data is held one more cycle
            weN <= 1'b1;
            ceN <= 1'b1;
            state <= nvc_pkg::ST_PRECHG;
          end
        end
        nvc_pkg::ST_PRECHG:
        begin
          dataBusOe <= 1'b0;
          upperByteSelectN <= 1'b1;
          lowerByteSelectN <= 1'b1;
          if (tmrDone)
          begin
            // a sleep may follow a finished write at once
            reqReady <= !pendValid;
            state <= nvc_pkg::ST_IDLE;
          end
        end
        nvc_pkg::ST_SLEEP:
        begin
          if (wakeUp)
          begin
            sleepRequestN <= 1'b1;
            state <= nvc_pkg::ST_WAKE;
          end
        end
        nvc_pkg::ST_WAKE:
        begin
          if (tmrDone)
          begin
            asleep <= 1'b0;
            reqReady <= 1'b1;
            state <= nvc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= nvc_pkg::ST_IDLE;
          reqReady <= 1'b0;
        end
      endcase
    end
  end

  // read data sampled at the end of the access wait
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rspValid <= 1'b0;
      rspRdata <= 16'h0000;
    end
    else
    begin
      rspValid <= ((state == nvc_pkg::ST_RD_ACC) || (state == nvc_pkg::ST_PG_ACC)) && tmrDone;
      if (((state == nvc_pkg::ST_RD_ACC) || (state == nvc_pkg::ST_PG_ACC)) && tmrDone)
        rspRdata <= dataBusIn;
    end
  end

  // helper counters for the hold-off checks
  localparam int ZZL_CYC = `NVC_ZZL_CYC;
  logic [`NVC_CNT_W-1:0] zzLowCnt;
  logic [`NVC_CNT_W-1:0] wakeCnt;
  logic [`NVC_CNT_W-1:0] puCnt;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      zzLowCnt <= `NVC_CNT_ZERO;
      wakeCnt <= {`NVC_CNT_W{1'b1}};
      puCnt <= `NVC_CNT_ZERO;
    end
    else
    begin
      zzLowCnt <= sleepRequestN ? `NVC_CNT_ZERO : zzLowCnt + 20'h00001;
      if (!sleepRequestN)
        wakeCnt <= `NVC_CNT_ZERO;
      else if (wakeCnt != {`NVC_CNT_W{1'b1}})
        wakeCnt <= wakeCnt + 20'h00001;
      if (puCnt != {`NVC_CNT_W{1'b1}})
        puCnt <= puCnt + 20'h00001;
    end
  end

  sequence wrEnter;
    $fell(weN) && !ceN;
  endsequence

  sequence wrHold;
    (!weN && dataBusOe)[*7] ##1 (weN && ceN);
  endsequence

  AST_SLEEP_LOW_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(sleepRequestN) |-> (zzLowCnt >= 20'(ZZL_CYC - 1)))
    else $error("sleep request released too early");

  AST_WAKE_HOLDOFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(ceN) |-> (wakeCnt >= 20'(WAKE_CYCLES - 1)))
    else $error("access too soon after wake");

  AST_PU_HOLDOFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(ceN) |-> (puCnt >= 20'(PU_CYCLES - 1)))
    else $error("access too soon after power-up");

  AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(sleepRequestN) |-> (ceN && weN && !dataBusOe && asleep))
    else $error("sleep entered during an access");

  AST_SLEEP_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sleepRequestN |-> (ceN && !dataBusOe && !reqReady))
    else $error("bus active while asleep");

  AST_PAGE_COLUMN_STABLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($changed(pageColumnBits) && !ceN && !$past(ceN)) |=> ($stable(pageColumnBits) && !rspValid) ##1 rspValid)
    else $error("page column bits changed too soon");

  AST_BYTE_SELECTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(ceN) |-> ({upperByteSelectN, lowerByteSelectN} == ~$past(pendBe)))
    else $error("byte selects do not follow the request");

  AST_WRITE_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrEnter |-> wrHold)
    else $error("write pulse or data hold wrong");

endmodule

// file: test/nvc_mem_model.sv
// behavioural model of the nonvolatile sram seen by the host controller
`timescale 1ns/1ps

module nvc_mem_model (
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic upperByteSelectN,
  input wire logic lowerByteSelectN,
  input wire logic sleepRequestN,
  input wire logic [14:0] upperAddressBits,
  input wire logic [1:0] pageColumnBits,
  input wire logic [15:0] busLevel,
  output logic [15:0] memOut
);
  logic [15:0] mem [0:131071];
  logic [16:0] wrAddr;
  logic wrOpen = 1'b0;
  logic [16:0] addr;

  assign addr = {upperAddressBits, pageColumnBits};

  // one process sees both enables, so a fall or rise of both in one step works in either order;
  // write opens when both are low and no sleep is requested, first rise closes it
  always @(ceN or weN)
  begin
    if (!ceN && !weN && sleepRequestN && !wrOpen)
    begin
      wrOpen = 1'b1;
      wrAddr = {upperAddressBits, pageColumnBits};
    end
    else if ((ceN || weN) && wrOpen)
    begin
      if (!upperByteSelectN)
        mem[wrAddr][15:8] = busLevel[15:8];
      if (!lowerByteSelectN)
        mem[wrAddr][7:0] = busLevel[7:0];
      wrOpen = 1'b0;
    end
  end

  // undriven lanes show the inverse, so a host never reads stale data by luck
  always_comb
  begin
    memOut = ~mem[addr];
    if (sleepRequestN && !ceN && weN && !oeN)
    begin
      if (!upperByteSelectN)
        memOut[15:8] = mem[addr][15:8];
      if (!lowerByteSelectN)
        memOut[7:0] = mem[addr][7:0];
    end
  end
endmodule

// file: test/tb_nvc_host.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps

module tb_nvc_host;
  localparam int PU = 20;
  localparam int WK = 10;
  logic clk_sys, sys_rst, reqValid, reqReady, reqWrite, rspValid, sleepReq, asleep;
  logic ceN, weN, oeN, upperByteSelectN, lowerByteSelectN, sleepRequestN, dataBusOe;
  logic [16:0] reqAddr;
  logic [15:0] reqWdata, rspRdata, hostOut, memOut, busLevel;
  logic [1:0] reqByteEn, pageColumnBits;
  logic [14:0] upperAddressBits;
  int errorCnt = 0;
  int comparisons = 0;

  assign busLevel = dataBusOe ? hostOut : memOut;

  nvc_host #(.PU_CYCLES(PU), .WAKE_CYCLES(WK)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .reqByteEn(reqByteEn), .rspValid(rspValid), .rspRdata(rspRdata),
    .sleepReq(sleepReq), .asleep(asleep), .ceN(ceN), .weN(weN), .oeN(oeN),
    .upperByteSelectN(upperByteSelectN), .lowerByteSelectN(lowerByteSelectN),
    .sleepRequestN(sleepRequestN), .upperAddressBits(upperAddressBits),
    .pageColumnBits(pageColumnBits), .dataBusIn(busLevel), .dataBusOut(hostOut), .dataBusOe(dataBusOe));

  nvc_mem_model u_mem (.ceN(ceN), .weN(weN), .oeN(oeN), .upperByteSelectN(upperByteSelectN),
    .lowerByteSelectN(lowerByteSelectN), .sleepRequestN(sleepRequestN),
    .upperAddressBits(upperAddressBits), .pageColumnBits(pageColumnBits), .busLevel(busLevel),
    .memOut(memOut));

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finishTest();
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a wait that runs out ends the run as a failure
  task automatic guard(input int n);
    if (n > 2000)
    begin
      errorCnt++;
      finishTest();
    end
  endtask

  // request held from a falling edge until the rising edge that takes it
  task automatic req(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    // one spare edge so back-to-back calls never lower and raise valid in one step
    @(negedge clk_sys);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqWdata = d;
    reqByteEn = be;
    while (reqReady !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    @(negedge clk_sys);
    reqValid = 1'b0;
  endtask

  // read returns data and falling edges from take to response
  task automatic rd(input logic [16:0] a, input logic [1:0] be, output logic [15:0] q, output int n);
    req(1'b0, a, 16'h0000, be);
    n = 0;
    while (rspValid !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    q = rspRdata;
  endtask

  task automatic testPowerUp();
    int n;
    n = 0;
    while (reqReady !== 1'b1)
    begin
      check(ceN, 1'b1);
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    check(n >= PU - 1, 1);
  endtask

  task automatic testLanes();
    logic [15:0] q;
    int n;
    req(1'b1, 17'h00123, 16'ha5c3, 2'b11);
    req(1'b1, 17'h00123, 16'h5a00, 2'b10);
    rd(17'h00123, 2'b11, q, n);
    check(q, 16'h5ac3);
    check(n, 8);
    rd(17'h00123, 2'b01, q, n);
    check(q[7:0], 8'hc3);
    check(q[15:8], 8'ha5);
    check(upperByteSelectN, 1'b1);
    check(lowerByteSelectN, 1'b0);
    check({oeN, weN}, 2'b01);
  endtask

  task automatic testPage();
    logic [15:0] q;
    int n;
    req(1'b1, 17'h00120, 16'h1111, 2'b11);
    req(1'b1, 17'h00121, 16'h2222, 2'b11);
    req(1'b1, 17'h00200, 16'h3333, 2'b11);
    rd(17'h00120, 2'b11, q, n);
    check(q, 16'h1111);
    rd(17'h00121, 2'b11, q, n);
    check(q, 16'h2222);
    check(n, 2);
    check(ceN, 1'b0);
    rd(17'h00200, 2'b11, q, n);
    check(q, 16'h3333);
    check(n, 12);
  endtask

  task automatic testSleep();
    logic [15:0] q;
    int n;
    req(1'b1, 17'h00300, 16'h3c5a, 2'b11);
    sleepReq = 1'b1;
    n = 0;
    while (sleepRequestN !== 1'b0)
    begin
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    sleepReq = 1'b0;
    check(asleep, 1'b1);
    n = 0;
    while (sleepRequestN !== 1'b1)
    begin
      check(dataBusOe, 1'b0);
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    check(n >= 100, 1);
    n = 0;
    while (reqReady !== 1'b1)
    begin
      check(ceN, 1'b1);
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    check(n >= WK - 1, 1);
    rd(17'h00300, 2'b11, q, n);
    check(q, 16'h3c5a);
    // sleep asked while a page is still open must close it first
    sleepReq = 1'b1;
    n = 0;
    while (sleepRequestN !== 1'b0)
    begin
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    sleepReq = 1'b0;
    check(ceN, 1'b1);
    check(asleep, 1'b1);
    n = 0;
    while (reqReady !== 1'b1)
    begin
      check(ceN, 1'b1);
      @(negedge clk_sys);
      n++;
      guard(n);
    end
    check(n >= 100 + WK - 1, 1);
    rd(17'h00300, 2'b11, q, n);
    check(q, 16'h3c5a);
  endtask

  // inputs settle at time zero, then each scenario runs in turn
  initial
  begin
    sys_rst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 17'h00000;
    reqWdata = 16'h0000;
    reqByteEn = 2'b00;
    sleepReq = 1'b0;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    testPowerUp();
    testLanes();
    testPage();
    testSleep();
    finishTest();
  end
endmodule
